// File: bwpl_lock.sv
// password controlled write protection lock with an apb register
// Functional notes
// RULE1: scheme setting 00 disables protection; protected bits are writable freely.
// RULE2: scheme resets to 11; any non-00 value acts as enabled.
// RULE3: scheme changes only together with mode-change key 11000.
// RULE4: status bit 2 reads 0 when writable, 1 when blocked.
// RULE5: key 10011 with scheme enabled opens access, clears status.
// RULE6: key 10101 with scheme enabled closes access, sets status.
// RULE7: any other key value changes neither state nor scheme.
// RULE8: after reset access is closed; blocked writes are dropped silently.
module bwpl_lock (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             prot_write_en
);

	// ----------------------------------------------------------------
	// usage notes
	// ----------------------------------------------------------------
	// the lock only drives a gate; the guarded bits live in other
	// registers, which must qualify their own write strobes with it.
	// a guarded write while the gate is low is dropped with no error,
	// so software that needs certainty reads the status bit first.
	// the gate is combinational from three flops and moves in the cycle
	// after the keyed write; a guarded write issued in that same cycle
	// still sees the old gate value.
	// the key field is write only and reads zero, so a password cannot
	// be learned by reading the register back.
	// the mode key loads any two-bit value; only zero turns the scheme
	// off, every other code behaves as enabled.
	// turning the scheme off keeps the open or closed state, so turning
	// it back on returns to whatever state was last keyed in.
	// open and close keys written while the scheme is off are ignored,
	// which keeps a stale key from changing the state later.
	// reads are decoded in the setup cycle so the data stands for the
	// whole access phase with no wait state.

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic       wr_acc;
	logic       rd_acc;
	logic       hit;
	logic [4:0] key;
	logic [1:0] mode_reg;
	logic       closed_reg;
	logic       enabled;
	logic       protection_active_flag;
	logic       keyed_wr;

	// zero wait states; unmapped words read zero, no error
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign hit     = (paddr[bwpl_pkg::ADDR_MSB:bwpl_pkg::ADDR_LSB]
		== bwpl_pkg::KEY_CTRL_ADDR[bwpl_pkg::ADDR_MSB:bwpl_pkg::ADDR_LSB]);
	assign wr_acc  = psel && penable && pwrite && hit;
	assign rd_acc  = psel && !penable && !pwrite;
	assign key     = pwdata[bwpl_pkg::KEY_MSB:bwpl_pkg::KEY_LSB];
	// RULE2 non-zero is enabled
	assign enabled = (mode_reg != bwpl_pkg::MODE_OFF);
	// helper for the gate checks: a write carrying one of the live keys
	assign keyed_wr = wr_acc && (key == bwpl_pkg::KEY_OPEN || key == bwpl_pkg::KEY_CLOSE
		|| key == bwpl_pkg::KEY_MODE_CHG);

	// ----------------------------------------------------------------
	// scheme setting
	// ----------------------------------------------------------------
	// RULE3 mode-change key gate
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= bwpl_pkg::MODE_ON;
		end else if (wr_acc && key == bwpl_pkg::KEY_MODE_CHG) begin
			mode_reg <= pwdata[bwpl_pkg::MODE_MSB:bwpl_pkg::MODE_LSB];
		end
	end

	// ----------------------------------------------------------------
	// protection state
	// ----------------------------------------------------------------
	// RULE5 RULE6 open and close keys; other keys ignored (RULE7)
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			closed_reg <= bwpl_pkg::PROT_RESET;
		end else if (wr_acc && enabled && key == bwpl_pkg::KEY_OPEN) begin
			closed_reg <= 1'b0;
		end else if (wr_acc && enabled && key == bwpl_pkg::KEY_CLOSE) begin
			closed_reg <= 1'b1;
		end
	end

	// RULE1 RULE8 scheme off always writable, closed drops writes
	assign prot_write_en = !enabled || !closed_reg;

	// RULE4 status set only when enabled and closed
	assign protection_active_flag = enabled && closed_reg;

	// ----------------------------------------------------------------
	// read data, registered in setup so it stands through access
	// ----------------------------------------------------------------
	// RULE4 status bit shows blocking
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= bwpl_pkg::RDATA_ZERO;
		end else if (rd_acc) begin
			prdata <= bwpl_pkg::RDATA_ZERO;
			if (hit) begin
				prdata[bwpl_pkg::MODE_MSB:bwpl_pkg::MODE_LSB] <= mode_reg;
				prdata[bwpl_pkg::PROT_BIT] <= protection_active_flag;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// named steps of a bus transfer, shared by the multi-step checks
	sequence bwpl_seq_setup_rd;
		psel && !penable && !pwrite && hit;
	endsequence

	// the access cycle that follows a read setup
	sequence bwpl_seq_access_rd;
		psel && penable && !pwrite;
	endsequence

	// a completed write to the key control word with key value k
	sequence bwpl_seq_key_wr(logic [4:0] k);
		wr_acc && (key == k);
	endsequence

	// one cycle with no write, then a read setup of the key word
	sequence bwpl_seq_gap_then_rd;
		!wr_acc ##1 bwpl_seq_setup_rd;
	endsequence

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// RULE1 off means open
	AST_MODE_OFF_OPEN: assert property ( // RULE1
		@(posedge mclk) disable iff (!rst_n)
		(mode_reg == bwpl_pkg::MODE_OFF) |-> prot_write_en)
		else $error("scheme off but writes blocked");

	// RULE3 plain writes ignored
	AST_MODE_PLAIN_WRITE: assert property ( // RULE3
		@(posedge mclk) disable iff (!rst_n)
		(wr_acc && key != bwpl_pkg::KEY_MODE_CHG) |=> $stable(mode_reg))
		else $error("scheme changed without key");

	// RULE3 keyed write loads
	AST_MODE_KEYED: assert property ( // RULE3
		@(posedge mclk) disable iff (!rst_n)
		bwpl_seq_key_wr(bwpl_pkg::KEY_MODE_CHG)
		|=> mode_reg == $past(pwdata[bwpl_pkg::MODE_MSB:bwpl_pkg::MODE_LSB]))
		else $error("keyed scheme write lost");

	// RULE5 open key opens
	AST_OPEN: assert property ( // RULE5
		@(posedge mclk) disable iff (!rst_n)
		(bwpl_seq_key_wr(bwpl_pkg::KEY_OPEN) ##0 enabled) |=> !closed_reg)
		else $error("open key did not open");

	// RULE6 close key closes
	AST_CLOSE: assert property ( // RULE6
		@(posedge mclk) disable iff (!rst_n)
		(bwpl_seq_key_wr(bwpl_pkg::KEY_CLOSE) ##0 enabled) |=> closed_reg)
		else $error("close key did not close");

	// RULE7 other keys inert
	AST_OTHER_KEY: assert property ( // RULE7
		@(posedge mclk) disable iff (!rst_n)
		(wr_acc && key != bwpl_pkg::KEY_OPEN && key != bwpl_pkg::KEY_CLOSE)
		|=> $stable(closed_reg))
		else $error("state changed by other key");

	// RULE8 closed blocks writes
	AST_ENABLED_GATE: assert property ( // RULE8
		@(posedge mclk) disable iff (!rst_n)
		(enabled && closed_reg) |-> !prot_write_en)
		else $error("closed but writable");

	// RULE4 status bit readback
	AST_STATUS_READ: assert property ( // RULE4
		@(posedge mclk) disable iff (!rst_n)
		(rd_acc && hit) |=> prdata[bwpl_pkg::PROT_BIT] == !$past(prot_write_en))
		else $error("status bit wrong");

	// RULE2 reset to enabled
	// checked without a disable so the first edge after release is seen
	AST_RESET_ON: assert property ( // RULE2
		@(posedge mclk)
		$rose(rst_n) |-> (mode_reg == bwpl_pkg::MODE_ON && closed_reg))
		else $error("bad reset state");

	// RULE8 reset leaves gate closed
	AST_RESET_CLEAN: assert property ( // RULE8
		@(posedge mclk)
		$rose(rst_n) |-> (prdata == bwpl_pkg::RDATA_ZERO && !prot_write_en))
		else $error("gate or read data wrong after reset");

	// RULE4 flag tracks gate
	AST_STATUS_LEVEL: assert property ( // RULE4
		@(posedge mclk) disable iff (!rst_n)
		protection_active_flag == !prot_write_en)
		else $error("status flag disagrees with write gate");

	// RULE8 never an error
	// a blocked write must vanish quietly, so the bus never flags it
	AST_NO_SLVERR: assert property ( // RULE8
		@(posedge mclk) disable iff (!rst_n)
		(psel && penable) |-> !pslverr)
		else $error("error response on access");

	// RULE8 no wait states
	AST_PREADY_HIGH: assert property ( // RULE8
		@(posedge mclk) disable iff (!rst_n)
		(psel && penable) |-> pready)
		else $error("access stalled");

	// RULE5 key reads zero
	AST_KEY_READS_ZERO: assert property ( // RULE5
		@(posedge mclk) disable iff (!rst_n)
		bwpl_seq_setup_rd |=> prdata[bwpl_pkg::KEY_MSB:bwpl_pkg::KEY_LSB] == 5'h00)
		else $error("key field visible on read");

	// RULE4 reserved bits zero
	AST_RESERVED_ZERO: assert property ( // RULE4
		@(posedge mclk) disable iff (!rst_n)
		bwpl_seq_setup_rd |=> prdata[bwpl_pkg::RSVD_MSB:bwpl_pkg::RSVD_LSB] == 24'h00_0000)
		else $error("reserved bits not zero");

	// RULE8 unmapped reads zero
	// an unmapped word must not leak the lock state
	AST_UNMAPPED_ZERO: assert property ( // RULE8
		@(posedge mclk) disable iff (!rst_n)
		(rd_acc && !hit) |=> prdata == bwpl_pkg::RDATA_ZERO)
		else $error("unmapped read not zero");

	// RULE2 scheme readback
	AST_MODE_READBACK: assert property ( // RULE2
		@(posedge mclk) disable iff (!rst_n)
		(rd_acc && hit) |=> prdata[bwpl_pkg::MODE_MSB:bwpl_pkg::MODE_LSB] == $past(mode_reg))
		else $error("scheme readback wrong");

	// RULE1 off ignores keys
	AST_OFF_IGNORES_KEYS: assert property ( // RULE1
		@(posedge mclk) disable iff (!rst_n)
		(wr_acc && !enabled && key != bwpl_pkg::KEY_MODE_CHG)
		|=> ($stable(closed_reg) && $stable(mode_reg)))
		else $error("key acted while scheme off");

	// RULE4 read data stands
	// data loaded in setup must not move before the access edge takes it
	AST_PRDATA_HOLD: assert property ( // RULE4
		@(posedge mclk) disable iff (!rst_n)
		(bwpl_seq_setup_rd ##1 bwpl_seq_access_rd) |=> $stable(prdata))
		else $error("read data moved during access");

	// RULE5 open then read
	AST_OPEN_THEN_READ: assert property ( // RULE5
		@(posedge mclk) disable iff (!rst_n)
		(bwpl_seq_key_wr(bwpl_pkg::KEY_OPEN) ##0 enabled ##1 bwpl_seq_gap_then_rd)
		|=> !prdata[bwpl_pkg::PROT_BIT])
		else $error("status still set after open");

	// RULE6 close then read
	AST_CLOSE_THEN_READ: assert property ( // RULE6
		@(posedge mclk) disable iff (!rst_n)
		(bwpl_seq_key_wr(bwpl_pkg::KEY_CLOSE) ##0 enabled ##1 bwpl_seq_gap_then_rd)
		|=> prdata[bwpl_pkg::PROT_BIT])
		else $error("status clear after close");

	// RULE3 scheme then read
	AST_MODE_THEN_READ: assert property ( // RULE3
		@(posedge mclk) disable iff (!rst_n)
		(bwpl_seq_key_wr(bwpl_pkg::KEY_MODE_CHG) ##1 bwpl_seq_gap_then_rd)
		|=> prdata[bwpl_pkg::MODE_MSB:bwpl_pkg::MODE_LSB]
		== $past(pwdata[bwpl_pkg::MODE_MSB:bwpl_pkg::MODE_LSB], 3))
		else $error("keyed scheme not read back");

	// RULE2 other codes enabled
	AST_NONZERO_ENABLED: assert property ( // RULE2
		@(posedge mclk) disable iff (!rst_n)
		(wr_acc && key == bwpl_pkg::KEY_OPEN && mode_reg != bwpl_pkg::MODE_OFF
		&& mode_reg != bwpl_pkg::MODE_ON) |=> !closed_reg)
		else $error("odd scheme code not enabled");

	// RULE7 gate needs key
	// the gate may move only in the cycle after a write with a live key
	AST_GATE_NEEDS_KEY: assert property ( // RULE7
		@(posedge mclk) disable iff (!rst_n)
		$changed(prot_write_en) |-> $past(keyed_wr))
		else $error("gate moved without a key");

	// RULE7 unmapped writes inert
	AST_UNMAPPED_WRITE: assert property ( // RULE7
		@(posedge mclk) disable iff (!rst_n)
		(psel && penable && pwrite && !hit) |=> ($stable(mode_reg) && $stable(closed_reg)))
		else $error("unmapped write changed the lock");

endmodule : bwpl_lock

// File: bwpl_lock_tb_top.sv
// testbench for the bit write protection lock
module bwpl_lock_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// signals and counters
	// ----------------------------------------------------------------
	logic        mclk = 1'b0;
	logic        rst_n, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, wq;
	logic        pready, pslverr, prot_write_en;
	int          mismatches = 0;
	int          n_checks = 0;
	int          cyc = 0;

	bwpl_lock bwpl_lock_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prot_write_en(prot_write_en));

	// free running clock, 8 ns period
	initial begin
		forever #4 mclk = ~mclk;
	end

	// one apb transfer; waits on pready, the timeout bounds the wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// status bit written as 1 on purpose: it must stay read only
	task automatic wr_key(input logic [4:0] key, input logic [1:0] mode);
		apb(1'b1, bwpl_pkg::KEY_CTRL_ADDR, {24'h00_0000, key, 1'b1, mode}, wq);
	endtask : wr_key

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic en);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
		chk({31'h0000_0000, prot_write_en}, {31'h0000_0000, en});
		chk({31'h0000_0000, pslverr}, 32'h0000_0000);
	endtask : rd

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// a hang ends here as a mismatch
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0007, 1'b0);
		wr_key(bwpl_pkg::KEY_OPEN, 2'h0);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0003, 1'b1);
		wr_key(bwpl_pkg::KEY_CLOSE, 2'h0);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0007, 1'b0);
		wr_key(bwpl_pkg::KEY_OPEN, 2'h0);
		wr_key(5'h1F, 2'h0);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0003, 1'b1);
		wr_key(bwpl_pkg::KEY_CLOSE, 2'h0);
		wr_key(bwpl_pkg::KEY_MODE_CHG, bwpl_pkg::MODE_OFF);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0000, 1'b1);
		wr_key(bwpl_pkg::KEY_CLOSE, 2'h3);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0000, 1'b1);
		wr_key(bwpl_pkg::KEY_MODE_CHG, 2'h1);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0005, 1'b0);
		wr_key(bwpl_pkg::KEY_OPEN, 2'h0);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0001, 1'b1);
		apb(1'b1, 12'h010, {24'h00_0000, bwpl_pkg::KEY_CLOSE, 3'h3}, wq);
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0001, 1'b1);
		rd(12'h010, 32'h0000_0000, 1'b1);
		// reset again in mid-run: the lock must come back enabled and closed
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(bwpl_pkg::KEY_CTRL_ADDR, 32'h0000_0007, 1'b0);
		stop_test();
	end
endmodule : bwpl_lock_tb_top

// File: bwpl_pkg.sv
// package of constants for the bit write protection lock
package bwpl_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] KEY_CTRL_ADDR = 12'h000;

	// ----------------------------------------------------------------
	// field layout of the key control register
	// ----------------------------------------------------------------
	localparam int MODE_LSB  = 0;
	localparam int MODE_MSB  = 1;
	localparam int PROT_BIT  = 2;
	localparam int KEY_LSB   = 3;
	localparam int KEY_MSB   = 7;
	localparam int ADDR_LSB  = 2;
	localparam int ADDR_MSB  = 11;
	localparam int RSVD_LSB  = 8;
	localparam int RSVD_MSB  = 31;

	// ----------------------------------------------------------------
	// scheme settings, key values and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_OFF     = 2'h0;
	localparam logic [1:0] MODE_ON      = 2'h3;
	localparam logic [4:0] KEY_MODE_CHG = 5'h18;
	localparam logic [4:0] KEY_OPEN     = 5'h13;
	localparam logic [4:0] KEY_CLOSE    = 5'h15;
	localparam logic       PROT_RESET   = 1'h1;
	localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

endpackage : bwpl_pkg
